// *** src/ccsr_regs.sv ***
/*
  Byte-wide configuration and status register bank of a buck-boost
  power controller. Holds the output target code, the control and the
  two configuration registers, and presents live status and fault bits.
  Assumes an I2C target on the same clock delivering one-cycle read and
  write strobes with address and data, and analog status levels that
  arrive asynchronously and are synchronised here.
*/
module ccsr_regs (
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic FEEDBACK_DIVIDER_SELECT_I,
  input wire logic CONST_CURRENT_ACTIVE_I,
  input wire logic UNIT_BUSY_I,
  input wire logic UNIT_OFF_I,
  input wire logic OUTPUT_OVERVOLTAGE_I,
  input wire logic OUTPUT_OVERCURRENT_I,
  input wire logic INPUT_UNDERVOLTAGE_I,
  input wire logic TEMPERATURE_FAULT_I,
  input wire logic COMM_LOGIC_MEMORY_EVENT_I,
  input wire logic OTHER_FAULT_I,
  output logic [11:0] VOUT_TARGET_CODE_O,
  output logic VOUT_STEP_20MV_O,
  output logic [16:0] VOUT_TARGET_MV_O,
  output logic FORCE_OUTPUT_DISCHARGE_O,
  output logic POWER_STAGE_EN_O,
  output logic NEGATIVE_LIMIT_ENABLE_O,
  output logic AUX_LDO_ENABLE_O,
  output logic MONITOR_LIMITER_ENABLE_O,
  output logic HICCUP_ENABLE_O,
  output logic DUAL_SPREAD_ENABLE_O,
  output logic MICRO_SLEEP_ENABLE_O,
  output logic THERMAL_WARN_ENABLE_O,
  output logic [1:0] THERMAL_WARN_LEVEL_O,
  output logic [7:0] THERMAL_WARN_DEGC_O,
  output logic FAULT_PIN_INTERRUPT_MODE_O,
  output logic DIRECT_STARTUP_ENABLE_O,
  output logic BIAS_SUPPLY_PRIORITY_O,
  output logic TWO_PHASE_FORCED_PWM_O,
  output logic TWO_PHASE_POWER_SAVE_O
);

  localparam int ST_WIDTH_L = ccsr_pkg::ST_WIDTH;

  logic [7:0] tgt_lo_r;
  logic [3:0] tgt_hi_r;
  logic [1:0] ctrl_r;
  logic [6:0] cfg0_r;
  logic [7:0] cfg1_r;
  logic [ST_WIDTH_L-1:0] sync1_r;
  logic [ST_WIDTH_L-1:0] sync2_r;
  logic [7:0] rdata_r;
  logic [11:0] applied_r;
  logic [16:0] mv_r;
  logic stage_en_r;
  logic [7:0] degc_r;

  wire [ST_WIDTH_L-1:0] stat_async = {FEEDBACK_DIVIDER_SELECT_I, CONST_CURRENT_ACTIVE_I,
    UNIT_BUSY_I, UNIT_OFF_I, OUTPUT_OVERVOLTAGE_I, OUTPUT_OVERCURRENT_I,
    INPUT_UNDERVOLTAGE_I, TEMPERATURE_FAULT_I, COMM_LOGIC_MEMORY_EVENT_I, OTHER_FAULT_I};

  // address decode; status offsets get no write enable at all
  wire sel_lo = REG_ADDR_I == ccsr_pkg::OFS_TGT_LO;
  wire sel_hi = REG_ADDR_I == ccsr_pkg::OFS_TGT_HI;
  wire sel_pst = REG_ADDR_I == ccsr_pkg::OFS_PD_STATUS;
  wire sel_fault = REG_ADDR_I == ccsr_pkg::OFS_FAULT_SUM;
  wire sel_ctrl = REG_ADDR_I == ccsr_pkg::OFS_PD_CONTROL;
  wire sel_cfg0 = REG_ADDR_I == ccsr_pkg::OFS_CONFIG_0;
  wire sel_cfg1 = REG_ADDR_I == ccsr_pkg::OFS_CONFIG_1;
  wire wr_lo = REG_WR_I && sel_lo;
  wire wr_hi = REG_WR_I && sel_hi;
  wire wr_ctrl = REG_WR_I && sel_ctrl;
  wire wr_cfg0 = REG_WR_I && sel_cfg0;
  wire wr_cfg1 = REG_WR_I && sel_cfg1;

  // only implemented bits are kept, so unimplemented ones read back zero
  wire [7:0] wd_hi = REG_WDATA_I & ccsr_pkg::MSK_TGT_HI;
  wire [7:0] wd_ctrl = REG_WDATA_I & ccsr_pkg::MSK_PD_CONTROL;
  wire [7:0] wd_cfg0 = REG_WDATA_I & ccsr_pkg::MSK_CONFIG_0;

  // status is live: no latching, bits follow their synchronised sources
  wire [7:0] pd_status = 8'(sync2_r[ccsr_pkg::ST_CC]) << ccsr_pkg::BIT_CC_ACTIVE;
  wire [7:0] fault_sum = sync2_r[7:0];

  logic [7:0] rd_mux;
  always_comb
  begin
    if (sel_lo)
      rd_mux = tgt_lo_r;
    else if (sel_hi)
      rd_mux = {4'h0, tgt_hi_r};
    else if (sel_pst)
      rd_mux = pd_status;
    else if (sel_fault)
      rd_mux = fault_sum;
    else if (sel_ctrl)
      rd_mux = {6'h00, ctrl_r};
    else if (sel_cfg0)
      rd_mux = {1'h0, cfg0_r};
    else if (sel_cfg1)
      rd_mux = cfg1_r;
    else
      rd_mux = 8'h00;
  end

  wire [11:0] code_nxt = wr_hi ? {wd_hi[3:0], tgt_lo_r} : applied_r;
  wire [4:0] step_sel = sync2_r[ccsr_pkg::ST_FB_SEL] ? ccsr_pkg::STEP_20MV :
    ccsr_pkg::STEP_10MV;
  wire [16:0] mv_nxt = 17'(applied_r) * 17'(step_sel);

  logic [7:0] degc_nxt;
  always_comb
  begin
    case (cfg1_r[6:5])
      2'h0: degc_nxt = ccsr_pkg::THW_DEGC_0;
      2'h1: degc_nxt = ccsr_pkg::THW_DEGC_1;
      2'h2: degc_nxt = ccsr_pkg::THW_DEGC_2;
      default: degc_nxt = ccsr_pkg::THW_DEGC_3;
    endcase
  end

  // two flops on every analog status level before anything reads it
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= stat_async;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tgt_lo_r <= ccsr_pkg::RST_TGT_LO;
      tgt_hi_r <= ccsr_pkg::RST_TGT_HI[3:0];
    end
    else
    begin
      if (wr_lo)
        tgt_lo_r <= REG_WDATA_I;
      if (wr_hi)
        tgt_hi_r <= wd_hi[3:0];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ctrl_r <= ccsr_pkg::RST_PD_CONTROL[1:0];
      cfg0_r <= ccsr_pkg::RST_CONFIG_0[6:0];
      cfg1_r <= ccsr_pkg::RST_CONFIG_1;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= wd_ctrl[1:0];
      if (wr_cfg0)
        cfg0_r <= wd_cfg0[6:0];
      if (wr_cfg1)
        cfg1_r <= REG_WDATA_I;
    end
  end

  // the converter sees a new code only when the upper nibble lands, so a
  // lower byte written first never applies a half-updated target
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      applied_r <= {ccsr_pkg::RST_TGT_HI[3:0], ccsr_pkg::RST_TGT_LO};
      mv_r <= '0;
    end
    else
    begin
      applied_r <= code_nxt;
      mv_r <= mv_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      rdata_r <= 8'h00;
      stage_en_r <= 1'b0;
      degc_r <= ccsr_pkg::THW_DEGC_0;
    end
    else
    begin
      if (REG_RD_I)
        rdata_r <= rd_mux;
      // either enable bit alone turns the stage on
      stage_en_r <= cfg0_r[0] | ctrl_r[0];
      degc_r <= degc_nxt;
    end
  end

  assign REG_RDATA_O = rdata_r;
  assign VOUT_TARGET_CODE_O = applied_r;
  assign VOUT_STEP_20MV_O = sync2_r[ccsr_pkg::ST_FB_SEL];
  assign VOUT_TARGET_MV_O = mv_r;
  assign FORCE_OUTPUT_DISCHARGE_O = ctrl_r[1];
  assign POWER_STAGE_EN_O = stage_en_r;
  assign NEGATIVE_LIMIT_ENABLE_O = cfg0_r[6];
  assign AUX_LDO_ENABLE_O = cfg0_r[5];
  assign MONITOR_LIMITER_ENABLE_O = cfg0_r[4];
  assign HICCUP_ENABLE_O = cfg0_r[3];
  assign DUAL_SPREAD_ENABLE_O = cfg0_r[2];
  assign MICRO_SLEEP_ENABLE_O = cfg0_r[1];
  assign THERMAL_WARN_ENABLE_O = cfg1_r[7];
  assign THERMAL_WARN_LEVEL_O = cfg1_r[6:5];
  assign THERMAL_WARN_DEGC_O = degc_r;
  assign FAULT_PIN_INTERRUPT_MODE_O = cfg1_r[4];
  assign DIRECT_STARTUP_ENABLE_O = cfg1_r[3];
  assign BIAS_SUPPLY_PRIORITY_O = cfg1_r[2];
  assign TWO_PHASE_FORCED_PWM_O = cfg1_r[1];
  assign TWO_PHASE_POWER_SAVE_O = cfg1_r[0];

  default clocking dflt_cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  sequence rd_of(logic [7:0] ofs);
    REG_RD_I && REG_ADDR_I == ofs;
  endsequence

  sequence wr_of(logic [7:0] ofs);
    REG_WR_I && REG_ADDR_I == ofs;
  endsequence

  // a write and then a quiet cycle, so a registered follower has settled
  sequence wr_idle(logic [7:0] ofs);
    wr_of(ofs) ##1 !REG_WR_I;
  endsequence

  unimpl_read_zero_a: assert property (
    rd_of(ccsr_pkg::OFS_PD_CONTROL) |=> REG_RDATA_O[7:2] == 6'h00)
    else $error("unimplemented control bits read nonzero");

  hi_nibble_write_a: assert property (
    wr_of(ccsr_pkg::OFS_TGT_HI) ##1 !REG_WR_I ##1 rd_of(ccsr_pkg::OFS_TGT_HI) ##0 !REG_WR_I
    |=> REG_RDATA_O == {4'h0, $past(REG_WDATA_I[3:0], 3)})
    else $error("upper target readback differs from write");

  target_mv_a: assert property (
    1'b1 |=> VOUT_TARGET_MV_O ==
    17'($past(applied_r)) *
    ($past(sync2_r[ccsr_pkg::ST_FB_SEL]) ? 17'h14 : 17'h0A))
    else $error("target millivolts not code times step");

  lo_byte_write_a: assert property (
    wr_of(ccsr_pkg::OFS_TGT_LO) |=> tgt_lo_r == $past(REG_WDATA_I))
    else $error("lower target byte not stored");

  cc_live_a: assert property (
    rd_of(ccsr_pkg::OFS_PD_STATUS) |=>
    REG_RDATA_O == {1'b0, $past(sync2_r[ccsr_pkg::ST_CC]), 6'h00})
    else $error("constant current bit not live");

  busy_off_a: assert property (
    rd_of(ccsr_pkg::OFS_FAULT_SUM) |=> REG_RDATA_O[7:6] == $past(sync2_r[7:6]))
    else $error("busy or off bit wrong");

  fault_bits_a: assert property (
    ($stable(sync1_r) [*3]) ##0 rd_of(ccsr_pkg::OFS_FAULT_SUM) |=>
    REG_RDATA_O[5:3] == {$past(OUTPUT_OVERVOLTAGE_I, 2), $past(OUTPUT_OVERCURRENT_I, 2),
    $past(INPUT_UNDERVOLTAGE_I, 2)} || $past(sync1_r[5:3]) != $past(sync2_r[5:3]))
    else $error("voltage or current fault bit wrong");

  misc_fault_a: assert property (
    rd_of(ccsr_pkg::OFS_FAULT_SUM) |=> REG_RDATA_O[2:0] == $past(sync2_r[2:0]))
    else $error("temperature, comm or other bit wrong");

  discharge_a: assert property (
    wr_of(ccsr_pkg::OFS_PD_CONTROL) |=> FORCE_OUTPUT_DISCHARGE_O == $past(REG_WDATA_I[1]))
    else $error("discharge bit not applied");

  stage_enable_a: assert property (
    wr_idle(ccsr_pkg::OFS_CONFIG_0) |=>
    POWER_STAGE_EN_O == ($past(REG_WDATA_I[0], 2) | ctrl_r[0]))
    else $error("power stage enable wrong");

  ro_write_a: assert property (
    wr_of(ccsr_pkg::OFS_FAULT_SUM) or wr_of(ccsr_pkg::OFS_PD_STATUS) |=>
    $stable({tgt_lo_r, tgt_hi_r, ctrl_r, cfg0_r, cfg1_r}))
    else $error("status write changed a register");

  pair_apply_a: assert property (
    wr_of(ccsr_pkg::OFS_TGT_LO) |=> $stable(VOUT_TARGET_CODE_O))
    else $error("lower byte applied without upper nibble");

  hi_unimpl_a: assert property (
    rd_of(ccsr_pkg::OFS_TGT_HI) |=> REG_RDATA_O[7:4] == 4'h0)
    else $error("unimplemented upper target bits read nonzero");

  cfg0_unimpl_a: assert property (
    rd_of(ccsr_pkg::OFS_CONFIG_0) |=> !REG_RDATA_O[7])
    else $error("unimplemented config 0 bit reads nonzero");

  status_unimpl_a: assert property (
    rd_of(ccsr_pkg::OFS_PD_STATUS) |=> !REG_RDATA_O[7] && REG_RDATA_O[5:0] == 6'h00)
    else $error("unimplemented status bits read nonzero");

  hi_apply_a: assert property (
    wr_of(ccsr_pkg::OFS_TGT_HI) |=>
    VOUT_TARGET_CODE_O == {$past(REG_WDATA_I[3:0]), $past(tgt_lo_r)})
    else $error("target code not applied with upper nibble");

  stage_control_a: assert property (
    wr_idle(ccsr_pkg::OFS_PD_CONTROL) |=>
    POWER_STAGE_EN_O == ($past(REG_WDATA_I[0], 2) | cfg0_r[0]))
    else $error("control stage enable wrong");

  neg_limit_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_0) |=> NEGATIVE_LIMIT_ENABLE_O == $past(REG_WDATA_I[6]))
    else $error("negative limit enable not applied");

  aux_ldo_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_0) |=> AUX_LDO_ENABLE_O == $past(REG_WDATA_I[5]))
    else $error("aux regulator enable not applied");

  monitor_limiter_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_0) |=> MONITOR_LIMITER_ENABLE_O == $past(REG_WDATA_I[4]))
    else $error("monitor limiter enable not applied");

  hiccup_enable_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_0) |=> HICCUP_ENABLE_O == $past(REG_WDATA_I[3]))
    else $error("hiccup enable not applied");

  dual_spread_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_0) |=> DUAL_SPREAD_ENABLE_O == $past(REG_WDATA_I[2]))
    else $error("spread spectrum enable not applied");

  micro_sleep_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_0) |=> MICRO_SLEEP_ENABLE_O == $past(REG_WDATA_I[1]))
    else $error("micro sleep enable not applied");

  thermal_warn_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_1) |=>
    {THERMAL_WARN_ENABLE_O, THERMAL_WARN_LEVEL_O} == $past(REG_WDATA_I[7:5]))
    else $error("thermal warning fields not applied");

  warn_degc_a: assert property (
    wr_idle(ccsr_pkg::OFS_CONFIG_1) |=> THERMAL_WARN_DEGC_O ==
    ($past(REG_WDATA_I[6], 2) ?
    ($past(REG_WDATA_I[5], 2) ? ccsr_pkg::THW_DEGC_3 : ccsr_pkg::THW_DEGC_2) :
    ($past(REG_WDATA_I[5], 2) ? ccsr_pkg::THW_DEGC_1 : ccsr_pkg::THW_DEGC_0)))
    else $error("thermal threshold decode wrong");

  fault_pin_mode_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_1) |=> FAULT_PIN_INTERRUPT_MODE_O == $past(REG_WDATA_I[4]))
    else $error("fault pin mode not applied");

  direct_startup_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_1) |=> DIRECT_STARTUP_ENABLE_O == $past(REG_WDATA_I[3]))
    else $error("direct startup enable not applied");

  bias_priority_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_1) |=> BIAS_SUPPLY_PRIORITY_O == $past(REG_WDATA_I[2]))
    else $error("bias priority not applied");

  forced_pwm_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_1) |=> TWO_PHASE_FORCED_PWM_O == $past(REG_WDATA_I[1]))
    else $error("two phase forced pwm not applied");

  power_save_a: assert property (
    wr_of(ccsr_pkg::OFS_CONFIG_1) |=> TWO_PHASE_POWER_SAVE_O == $past(REG_WDATA_I[0]))
    else $error("two phase power save not applied");

endmodule // ccsr_regs

// *** src/ccsr_pkg.sv ***
/*
  Constants for the converter configuration and status register bank:
  byte offsets, reset values, writable-bit masks, status bit positions.
  Assumes an I2C target in front of the bank that turns each
  transaction into byte-wide read and write strobes on the core clock.
*/
// Contract
// - unimplemented bits ignore writes, read zero
// - upper target register holds code bits 11..8
// - code step is 20mV or 10mV by select
// - lower target byte at 0x0C, resets all ones
// - pd status bit 6 shows live constant-current
// - fault byte bit7 busy, bit6 off
// - fault bits 5,4,3: overvoltage, overcurrent, undervoltage
// - fault bits 2,1,0: temperature, comm event, other
// - control bit 1 forces output discharge
// - config0 bit0 and control bit0 enable stage
// - config0 bit6 limits negative inductor current too
// - config0 bit5 enables aux LDO, resets one
// - config0 bit4 sets monitor limiter, resets one
// - config0 bit3 enables hiccup protection, resets zero
// - config0 bit2 enables dual spread spectrum
// - config0 bit1 enables micro-sleep, resets one
// - config1 bit7 thermal warn, bits6-5 threshold
// - config1 bit4 fault pin interrupt mode
// - config1 bit3 direct start without tracking input
// - config1 bit2 prioritises bias pin supply
// - config1 bit1 two-phase in forced PWM
// - config1 bit0 two-phase in power save
package ccsr_pkg;
  localparam logic [7:0] OFS_TGT_LO = 8'h0C;
  localparam logic [7:0] OFS_TGT_HI = 8'h0D;
  localparam logic [7:0] OFS_PD_STATUS = 8'h21;
  localparam logic [7:0] OFS_FAULT_SUM = 8'h78;
  localparam logic [7:0] OFS_PD_CONTROL = 8'h81;
  localparam logic [7:0] OFS_CONFIG_0 = 8'hD0;
  localparam logic [7:0] OFS_CONFIG_1 = 8'hD1;

  localparam logic [7:0] RST_TGT_LO = 8'hFF;
  localparam logic [7:0] RST_TGT_HI = 8'h00;
  localparam logic [7:0] RST_PD_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONFIG_0 = 8'h32;
  localparam logic [7:0] RST_CONFIG_1 = 8'h19;

  // writable bits; everything else is unimplemented
  localparam logic [7:0] MSK_TGT_HI = 8'h0F;
  localparam logic [7:0] MSK_PD_CONTROL = 8'h03;
  localparam logic [7:0] MSK_CONFIG_0 = 8'h7F;
  localparam logic [7:0] MSK_CONFIG_1 = 8'hFF;

  localparam int BIT_CC_ACTIVE = 6;

  // synchronised status vector layout
  localparam int ST_FB_SEL = 9;
  localparam int ST_CC = 8;
  localparam int ST_WIDTH = 10;

  localparam logic [4:0] STEP_20MV = 5'h14;
  localparam logic [4:0] STEP_10MV = 5'h0A;

  // thermal warning thresholds in degC, indexed by the 2-bit level
  localparam logic [7:0] THW_DEGC_0 = 8'h8C;
  localparam logic [7:0] THW_DEGC_1 = 8'h7D;
  localparam logic [7:0] THW_DEGC_2 = 8'h6E;
  localparam logic [7:0] THW_DEGC_3 = 8'h5F;
endpackage : ccsr_pkg

// *** tb/ccsr_host.sv ***
/*
  Host-side model of the register port: byte write and read cycles.
  Assumes the bank takes a strobe on the rising edge and answers reads
  one cycle later.
*/
module ccsr_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // an idle bus shows inverted values, so a stale address never looks live
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    d = rdata_i;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask
  // lower byte first so no half-updated code is applied
  task automatic wr_target(input logic [7:0] lo, input logic [7:0] hi);
    wr_byte(8'h0C, lo);
    wr_byte(8'h0D, hi);
  endtask
endmodule // ccsr_host

// *** tb/converter_config_status_regs_tb.sv ***
/*
  Self-checking bench for the register bank: table of register
  accesses, then target, status, stage, threshold and reset cases.
  Assumes the host model drives the register port.
*/
module converter_config_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] rst; logic [7:0] exp;} ccsr_row_t;
  localparam ccsr_row_t ROWS [8] = '{'{8'h0C, 8'h34, 8'hFF, 8'h34}, '{8'h0D, 8'hF5, 8'h00, 8'h05},
    '{8'h21, 8'hFF, 8'h00, 8'h00}, '{8'h78, 8'hFF, 8'h00, 8'h00}, '{8'h81, 8'hFF, 8'h00, 8'h03},
    '{8'hD0, 8'hFF, 8'h32, 8'h7F}, '{8'hD1, 8'hA5, 8'h19, 8'hA5}, '{8'h55, 8'hFF, 8'h00, 8'h00}};
  localparam logic [7:0] DEGC [4] = '{8'h8C, 8'h7D, 8'h6E, 8'h5F};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic fbsel = 1'b1;
  logic cc = 1'b0;
  logic [7:0] flt = 8'h00;
  logic [7:0] addr, wdata, rdata, v;
  logic wr, rd;
  logic [11:0] code;
  logic step20;
  logic [16:0] mv;
  logic disch, stage, therm_en, fint, direct, bias, forced_pwm, power_save;
  logic neg, aux, mon, hic, dual, slp;
  logic [1:0] lvl;
  logic [7:0] degc;
  int num_errors = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  ccsr_host u_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .wdata_o(wdata),
    .rd_o(rd));
  ccsr_regs u_dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .FEEDBACK_DIVIDER_SELECT_I(fbsel),
    .CONST_CURRENT_ACTIVE_I(cc), .UNIT_BUSY_I(flt[7]), .UNIT_OFF_I(flt[6]),
    .OUTPUT_OVERVOLTAGE_I(flt[5]), .OUTPUT_OVERCURRENT_I(flt[4]), .INPUT_UNDERVOLTAGE_I(flt[3]),
    .TEMPERATURE_FAULT_I(flt[2]), .COMM_LOGIC_MEMORY_EVENT_I(flt[1]), .OTHER_FAULT_I(flt[0]),
    .VOUT_TARGET_CODE_O(code), .VOUT_STEP_20MV_O(step20), .VOUT_TARGET_MV_O(mv),
    .FORCE_OUTPUT_DISCHARGE_O(disch), .POWER_STAGE_EN_O(stage), .NEGATIVE_LIMIT_ENABLE_O(neg),
    .AUX_LDO_ENABLE_O(aux), .MONITOR_LIMITER_ENABLE_O(mon), .HICCUP_ENABLE_O(hic),
    .DUAL_SPREAD_ENABLE_O(dual), .MICRO_SLEEP_ENABLE_O(slp), .THERMAL_WARN_ENABLE_O(therm_en),
    .THERMAL_WARN_LEVEL_O(lvl), .THERMAL_WARN_DEGC_O(degc), .FAULT_PIN_INTERRUPT_MODE_O(fint),
    .DIRECT_STARTUP_ENABLE_O(direct), .BIAS_SUPPLY_PRIORITY_O(bias),
    .TWO_PHASE_FORCED_PWM_O(forced_pwm), .TWO_PHASE_POWER_SAVE_O(power_save));
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check_outs(input logic [11:0] c, input logic [5:0] c0, input logic [7:0] c1,
    input logic [7:0] dg, input logic st, input logic ds, input logic [16:0] m);
    check(17'(code), 17'(c));
    check(17'({neg, aux, mon, hic, dual, slp}), 17'(c0));
    check(17'({therm_en, lvl, fint, direct, bias, forced_pwm, power_save}), 17'(c1));
    check(17'(degc), 17'(dg));
    check(mv, m);
    check(17'({stage, disch}), 17'({st, ds}));
  endtask
  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end
  initial
  begin
    wait_clk(3);
    rstn = 1'b1;
    check_outs(12'h0FF, 6'h19, 8'h19, 8'h8C, 1'b0, 1'b0, 17'h0);
    foreach (ROWS[i])
    begin
      u_host.rd_byte(ROWS[i].a, v);
      check(17'(v), 17'(ROWS[i].rst));
      u_host.wr_byte(ROWS[i].a, ROWS[i].d);
      u_host.rd_byte(ROWS[i].a, v);
      check(17'(v), 17'(ROWS[i].exp));
    end
    wait_clk(2);
    check_outs(12'h534, 6'h3F, 8'hA5, 8'h7D, 1'b1, 1'b1, 17'(12'h534) * 17'h14);
    check(mv, 17'(12'h534) * 17'h14);
    check(17'(step20), 17'h1);
    fbsel = 1'b0;
    wait_clk(4);
    check(mv, 17'(12'h534) * 17'h0A);
    check(17'(step20), 17'h0);
    u_host.wr_byte(8'h0C, 8'h77);
    wait_clk(2);
    check(17'(code), 17'h534);
    u_host.wr_target(8'h77, 8'h0A);
    wait_clk(2);
    check(17'(code), 17'hA77);
    for (int i = 0; i < 8; i++)
    begin
      flt = 8'h01 << i;
      wait_clk(2);
      u_host.rd_byte(8'h78, v);
      check(17'(v), 17'(8'h01 << i));
    end
    flt = 8'h00;
    cc = 1'b1;
    wait_clk(2);
    u_host.rd_byte(8'h21, v);
    check(17'(v), 17'h40);
    cc = 1'b0;
    wait_clk(2);
    u_host.rd_byte(8'h21, v);
    check(17'(v), 17'h00);
    u_host.wr_byte(8'h81, 8'h00);
    u_host.wr_byte(8'hD0, 8'h00);
    wait_clk(2);
    check(17'({stage, disch}), 17'h0);
    u_host.wr_byte(8'h81, 8'h01);
    wait_clk(2);
    check(17'(stage), 17'h1);
    u_host.wr_byte(8'h81, 8'h00);
    u_host.wr_byte(8'hD0, 8'h01);
    wait_clk(2);
    check(17'(stage), 17'h1);
    for (int l = 0; l < 4; l++)
    begin
      u_host.wr_byte(8'hD1, {1'b1, 2'(l), 5'h00});
      wait_clk(2);
      check(17'({therm_en, lvl, degc}), 17'({1'b1, 2'(l), DEGC[l]}));
    end
    rstn = 1'b0;
    wait_clk(3);
    rstn = 1'b1;
    check_outs(12'h0FF, 6'h19, 8'h19, 8'h8C, 1'b0, 1'b0, 17'h0);
    u_host.rd_byte(8'hD0, v);
    check(17'(v), 17'h32);
    close_out();
  end
endmodule // converter_config_status_regs_tb
